// file: bench/prog_rom_model.sv
`timescale 1ns/1ps
module prog_rom_model (
  // bus pins from the controller
  input wire logic addr_latch_strobe,
  input wire logic program_store_strobe_n,
  input wire logic [7:0] low_bus,
  input wire logic [7:0] high_port_out,
  // data back onto the muxed port
  output logic [7:0] rom_data,
  output logic rom_oe
);
  logic [7:0] low_addr_reg;
  logic [7:0] last_reg = 8'h00;
  logic [7:0] byte_next;
  // transparent latch, holds the low byte once the strobe falls
  always_latch if (addr_latch_strobe) low_addr_reg <= low_bus;
  // content is a fixed mix of both address bytes
  assign byte_next = low_addr_reg ^ high_port_out ^ 8'h5a;
  // released bus shows the inverse, so a stale byte never passes as data
  assign rom_oe = !program_store_strobe_n;
  assign rom_data = rom_oe ? byte_next : ~last_reg;
  always @(negedge program_store_strobe_n) last_reg <= byte_next;
endmodule : prog_rom_model

// file: bench/test_ext_program_memory_bus_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_ext_program_memory_bus_ctrl;
  logic sys_clk, rst, reset_pin, external_access_select;
  logic fetch_req, code_table_read, fetch_ack, fetch_external, core_reset;
  logic [15:0] fetch_addr;
  logic [7:0] fetch_data, low_port_out, high_port_out, rom_data, low_bus;
  logic addr_latch_strobe, program_store_strobe_n, rom_oe;
  logic low_port_oe_n, high_port_oe_n;
  int failures = 0, checks_done = 0, cycles = 0;
  int ale_cnt = 0, program_store_strobe_cnt = 0, clash = 0, bad_addr = 0;
  // ------------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------------
  assign low_bus = !low_port_oe_n ? low_port_out : rom_data;
  ext_program_memory_bus_ctrl u_dut (.sys_clk(sys_clk), .rst(rst),
    .reset_pin(reset_pin), .external_access_select(external_access_select),
    .fetch_req(fetch_req), .code_table_read(code_table_read),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
    .fetch_external(fetch_external), .fetch_data(fetch_data),
    .core_reset(core_reset), .addr_latch_strobe(addr_latch_strobe),
    .program_store_strobe_n(program_store_strobe_n),
    .low_port_out(low_port_out), .low_port_oe_n(low_port_oe_n),
    .low_port_in(low_bus), .high_port_out(high_port_out),
    .high_port_oe_n(high_port_oe_n));
  prog_rom_model u_rom (.addr_latch_strobe(addr_latch_strobe),
    .program_store_strobe_n(program_store_strobe_n), .low_bus(low_bus),
    .high_port_out(high_port_out), .rom_data(rom_data), .rom_oe(rom_oe));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // bus watch, sampled mid-cycle where everything has settled
  always @(negedge sys_clk) if (!rst) begin
    if (addr_latch_strobe) begin
      ale_cnt++;
      if (low_port_oe_n || high_port_oe_n) bad_addr++;
      if ({high_port_out, low_port_out} !== fetch_addr) bad_addr++;
    end
    if (!program_store_strobe_n) program_store_strobe_cnt++;
    if (!low_port_oe_n && rom_oe) clash++;
  end
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // short pulse must be ignored, a long one must reset the core
  task automatic test_reset();
    int hi;
    hi = 0;
    reset_pin = 1;
    repeat (4) @(posedge sys_clk);
    #1 reset_pin = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (core_reset) hi++;
    end
    `CHK("short_pulse", 0, hi)
    @(posedge sys_clk);
    #1 reset_pin = 1;
    repeat (11) @(posedge sys_clk);
    #1 `CHK("core_reset_early", 1'b0, core_reset)
    repeat (5) @(posedge sys_clk);
    #1 `CHK("core_reset", 1'b1, core_reset)
    reset_pin = 0;
    repeat (8) @(posedge sys_clk);
    #1 `CHK("core_reset_off", 1'b0, core_reset)
    $display("test reset done");
  endtask : test_reset
  task automatic access(input logic [15:0] a, input logic tbl,
                        input logic ext);
    int n;
    n = 0;
    ale_cnt = 0;
    program_store_strobe_cnt = 0;
    fetch_addr = a;
    fetch_req = !tbl;
    code_table_read = tbl;
    do begin
      @(negedge sys_clk);
      n++;
    end while (fetch_ack !== 1'b1 && n < 20);
    `CHK("ack_delay", 1'b1, n >= 5 && n <= 8)
    @(posedge sys_clk);
    #1 fetch_req = 0;
    code_table_read = 0;
    @(posedge sys_clk);
    #1 `CHK("fetch_external", ext, fetch_external)
    `CHK("latch_pulses", ext ? 1 : 0, ale_cnt)
    `CHK("store_clocks", ext ? 2 : 0, program_store_strobe_cnt)
    if (ext) `CHK("fetch_data", a[7:0] ^ a[15:8] ^ 8'h5a, fetch_data)
    $display("test access %h done", a);
  endtask : access
  initial begin
    rst = 1;
    reset_pin = 0;
    external_access_select = 1;
    fetch_req = 0;
    code_table_read = 0;
    fetch_addr = 16'h0000;
    repeat (10) @(posedge sys_clk);
    `CHK("idle_latch", 1'b0, addr_latch_strobe)
    `CHK("idle_store", 1'b1, program_store_strobe_n)
    `CHK("idle_oe", 1'b1, low_port_oe_n)
    #1 rst = 0;
    repeat (10) @(posedge sys_clk);
    #1 test_reset();
    access(16'h1234, 0, 0);
    access(16'h7fff, 1, 0);
    access(16'h8000, 0, 1);
    access(16'hff5a, 1, 1);
    external_access_select = 0;
    repeat (6) @(posedge sys_clk);
    #1 access(16'h0000, 0, 1);
    access(16'h7fff, 1, 1);
    `CHK("port_clash", 0, clash)
    `CHK("addr_phase", 0, bad_addr)
    report_and_stop();
  end
endmodule : test_ext_program_memory_bus_ctrl

// file: design/ext_program_memory_bus_ctrl.sv
`timescale 1ns/1ps
module ext_program_memory_bus_ctrl (
  // clock and raw reset pin
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_pin,
  // straps
  input wire logic external_access_select,
  // core request side
  input wire logic fetch_req,
  input wire logic code_table_read,
  input wire logic [15:0] fetch_addr,
  output logic fetch_ack,
  output logic fetch_external,
  output logic [7:0] fetch_data,
  output logic core_reset,
  // external bus
  output logic addr_latch_strobe,
  output logic program_store_strobe_n,
  output logic [7:0] low_port_out,
  output logic low_port_oe_n,
  input wire logic [7:0] low_port_in,
  output logic [7:0] high_port_out,
  output logic high_port_oe_n
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] rst_sync_reg;
  logic [2:0] sel_sync_reg;
  logic rst_pin_reg;
  logic sel_reg;

  // three flops; a change counts once second and third agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_sync_reg <= 3'h7;
      sel_sync_reg <= 3'h7;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], reset_pin};
      sel_sync_reg <= {sel_sync_reg[1:0], external_access_select};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_pin_reg <= 1'b1;
      sel_reg <= 1'b1;
    end else begin
      if (rst_sync_reg[1] == rst_sync_reg[2])
        rst_pin_reg <= rst_sync_reg[2];
      if (sel_sync_reg[1] == sel_sync_reg[2])
        sel_reg <= sel_sync_reg[2];
    end
  end

  // ------------------------------------------------------------------
  // machine cycle phase counter
  // ------------------------------------------------------------------
  logic [1:0] phase_reg;

  // free-running; one wrap is one machine cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      phase_reg <= progbus_pkg::PH_ADDR;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  // ------------------------------------------------------------------
  // reset qualification
  // ------------------------------------------------------------------
  logic [3:0] rst_cnt_reg;
  localparam logic [3:0] RST_CLKS = 4'(progbus_pkg::RESET_CLKS);

  // glitches shorter than two machine cycles never reset the core
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_reg <= 4'h0;
      core_reset <= 1'b1;
    end else if (!rst_pin_reg) begin
      rst_cnt_reg <= 4'h0;
      core_reset <= 1'b0;
    end else if (rst_cnt_reg < RST_CLKS - 4'h1) begin
      rst_cnt_reg <= rst_cnt_reg + 4'h1;
    end else begin
      core_reset <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------------
  function automatic logic is_external(input logic sel,
                                       input logic [15:0] addr);
    // internal only when select high and address inside 32 KB
    is_external = !sel ||
      (addr[15:progbus_pkg::INTERNAL_ROM_ADDR_BITS] != 1'b0);
  endfunction : is_external

  typedef enum {ST_IDLE, ST_INT, ST_EXT} acc_state_t;
  acc_state_t state_reg;
  logic [15:0] addr_reg;

  // a request is taken only in the last phase (PH_SAMPLE) of a machine cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      addr_reg <= progbus_pkg::ADDR_RESET;
    end else if (core_reset) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if ((fetch_req || code_table_read) &&
              phase_reg == progbus_pkg::PH_SAMPLE) begin
            addr_reg <= fetch_addr;
            state_reg <= is_external(sel_reg, fetch_addr) ? ST_EXT : ST_INT;
          end
        end
        ST_INT, ST_EXT: begin
          if (phase_reg == progbus_pkg::PH_SAMPLE)
            state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // bus drive: address, latch strobe, turnaround, program strobe
  // ------------------------------------------------------------------
  logic ext_now;
  assign ext_now = (state_reg == ST_EXT);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_latch_strobe <= 1'b0;
      program_store_strobe_n <= 1'b1;
      low_port_out <= progbus_pkg::DATA_RESET;
      low_port_oe_n <= 1'b1;
      high_port_out <= 8'h00;
      high_port_oe_n <= 1'b1;
    end else if (core_reset) begin
      // a core reset in mid-access must not leave a strobe stuck active
      addr_latch_strobe <= 1'b0;
      program_store_strobe_n <= 1'b1;
      low_port_oe_n <= 1'b1;
      high_port_oe_n <= 1'b1;
    end else begin
      // latch strobe is a one-clock pulse; only acceptance raises it
      addr_latch_strobe <= 1'b0;
      if (state_reg == ST_IDLE && !core_reset &&
          (fetch_req || code_table_read) &&
          phase_reg == progbus_pkg::PH_SAMPLE &&
          is_external(sel_reg, fetch_addr)) begin
        addr_latch_strobe <= 1'b1;
        low_port_out <= fetch_addr[7:0];
        low_port_oe_n <= 1'b0;
        high_port_out <= fetch_addr[15:8];
        high_port_oe_n <= 1'b0;
      end else if (ext_now && phase_reg == progbus_pkg::PH_ADDR) begin
        low_port_oe_n <= 1'b1;
      end else if (ext_now && phase_reg == progbus_pkg::PH_TURN) begin
        program_store_strobe_n <= 1'b0;
      end else if (ext_now && phase_reg == progbus_pkg::PH_SAMPLE) begin
        program_store_strobe_n <= 1'b1;
        high_port_oe_n <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // answer to the core
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_data <= progbus_pkg::DATA_RESET;
      fetch_external <= 1'b0;
    end else if (ext_now && phase_reg == progbus_pkg::PH_SAMPLE) begin
      fetch_data <= low_port_in;
      fetch_external <= 1'b1;
    end else if (state_reg == ST_INT &&
                 phase_reg == progbus_pkg::PH_SAMPLE) begin
      fetch_external <= 1'b0; // internal array supplies the byte
    end
  end

  assign fetch_ack = (state_reg != ST_IDLE) &&
                     (phase_reg == progbus_pkg::PH_SAMPLE);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_INT_NO_STROBE: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_reg == ST_INT |-> program_store_strobe_n)
    else $error("program strobe active on internal access");
  AST_INT_NO_DRIVE: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_reg == ST_INT |-> low_port_oe_n && high_port_oe_n)
    else $error("bus driven on internal access");
  AST_ALE_THEN_PROGRAM_STORE_STROBE: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(addr_latch_strobe) && ext_now |-> ##1 !program_store_strobe_n)
    else $error("program strobe not one clock after latch strobe");
  AST_RELEASE: assert property (
    @(posedge sys_clk) disable iff (rst)
    !program_store_strobe_n |-> low_port_oe_n)
    else $error("low port driven under program strobe");
  AST_ALE_ADDR: assert property (
    @(posedge sys_clk) disable iff (rst)
    addr_latch_strobe |-> !low_port_oe_n && low_port_out == addr_reg[7:0])
    else $error("latch strobe without low address");
  AST_HIGH_ADDR: assert property (
    @(posedge sys_clk) disable iff (rst)
    !program_store_strobe_n |-> !high_port_oe_n &&
      high_port_out == addr_reg[15:8])
    else $error("upper address missing");
  AST_MCYCLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    phase_reg == progbus_pkg::PH_ADDR |-> ##4
      phase_reg == progbus_pkg::PH_ADDR)
    else $error("machine cycle not four clocks");
  // eight qualified clocks: the count runs 0..7, the next edge sets reset
  AST_RESET_QUAL: assert property (
    @(posedge sys_clk) disable iff (rst)
    ($rose(rst_pin_reg) && !core_reset) ##1 rst_pin_reg [*7] |->
      !core_reset ##1 core_reset)
    else $error("reset not qualified after two machine cycles");
  AST_RESET_EARLY: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(rst_pin_reg) && !core_reset |-> !core_reset [*8])
    else $error("core reset before two machine cycles");
  AST_PROGRAM_STORE_STROBE_WIDTH: assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(program_store_strobe_n) |-> !program_store_strobe_n [*2]
      ##1 program_store_strobe_n)
    else $error("program strobe width wrong");
  AST_EXT_DECODE: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_reg == ST_IDLE && !core_reset && fetch_req &&
    phase_reg == progbus_pkg::PH_SAMPLE && !sel_reg |=> ext_now)
    else $error("select low did not force external fetch");

  CV_EXT_FETCH: cover property (@(posedge sys_clk) disable iff (rst)
    ext_now && fetch_ack);
  CV_INT_FETCH: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_INT && fetch_ack);
  CV_TABLE_READ: cover property (@(posedge sys_clk) disable iff (rst)
    code_table_read && addr_latch_strobe);
  CV_CORE_RESET: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(core_reset));
endmodule : ext_program_memory_bus_ctrl

// file: design/progbus_pkg.sv
package progbus_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLKS_PER_MCYCLE = 4;
  localparam int unsigned RESET_MCYCLES = 2;
  localparam int unsigned RESET_CLKS = RESET_MCYCLES * CLKS_PER_MCYCLE;
  // ------------------------------------------------------------------
  // memory map
  // ------------------------------------------------------------------
  localparam int unsigned INTERNAL_ROM_BYTES = 32768;
  localparam int unsigned INTERNAL_ROM_ADDR_BITS = 15;
  // ------------------------------------------------------------------
  // phases of a machine cycle (counter values), then reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_TURN = 2'h1;
  localparam logic [1:0] PH_STROBE = 2'h2;
  localparam logic [1:0] PH_SAMPLE = 2'h3;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
endpackage : progbus_pkg
